// File: rtl/pmic_device.sv
module pmic_device #(
  parameter int WARMUP_CYCLES  = pmic_pkg::WARMUP_CYCLES,
  parameter int INTEG_CYCLES   = pmic_pkg::INTEG_CYCLES,
  parameter int STEP_CYCLES    = pmic_pkg::STEP_CYCLES,
  parameter int RELEASE_CYCLES = pmic_pkg::RELEASE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  pmic_if.device          link,
  input  wire logic       adapter_supply_in,
  input  wire logic       usb_present_in,
  input  wire logic       battery_low_warn_in,
  input  wire logic       thermal_alarm_in,
  input  wire logic       thermal_shutdown_in,
  input  wire logic       safety_timer_expired_in,
  input  wire logic       standby_mode_in,
  input  wire logic       power_off_mode_in,
  input  wire logic       charger_standby_in,
  input  wire logic       integrator_zero_in,
  output logic [1:0]      source_select,
  output logic            range_wide,
  output logic            converter_powered,
  output logic            integrate_input,
  output logic            integrate_reference,
  output logic            force_standby
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_WARM  = 4'b0010,
    S_INTEG = 4'b0100,
    S_DEINT = 4'b1000
  } conv_state_e;

  localparam logic [16:0] WARM_LAST  = 17'(WARMUP_CYCLES - 1);
  localparam logic [16:0] INTEG_LAST = 17'(INTEG_CYCLES - 1);
  localparam logic [16:0] STEP_LAST  = 17'(STEP_CYCLES - 1);
  localparam logic [16:0] REL_LAST   = 17'(RELEASE_CYCLES - 1);
  localparam logic [16:0] COUNT_ZERO = 17'h0_0000;

  conv_state_e state_reg;
  logic [7:0]  converter_control_reg;
  logic [7:0]  converter_result_reg;
  logic [7:0]  interrupt_mask_reg;
  logic [7:0]  interrupt_request_reg;
  logic [7:0]  pending_hold_reg;
  logic [7:0]  interrupt_request_next;
  logic [7:0]  pending_hold_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  ref_steps_reg;
  logic [16:0] count_reg;
  logic [16:0] rst_count_reg;
  logic        irq_drive_reg;
  logic        rst_drive_reg;
  logic        warm_done_reg;
  logic        start_pending_reg;
  logic        adapter_prev_reg;
  logic        usb_prev_reg;
  logic        batt_prev_reg;
  logic        thermal_prev_reg;
  logic        timer_prev_reg;
  logic        force_standby_reg;
  logic [7:0]  events;
  logic        wr_ctrl;
  logic        start_write;
  logic        conv_done;
  logic        enabled;
  logic        irq_clear;
  logic        low_mode;

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] t);
    hit = strobe && (a == t);
  endfunction : hit

  assign enabled     = converter_control_reg[pmic_pkg::CC_ENABLE];
  assign wr_ctrl     = hit(link.wr, link.addr, pmic_pkg::ADDR_CONV_CTRL);
  assign start_write = wr_ctrl && link.wdata[pmic_pkg::CC_START]
                       && !converter_control_reg[pmic_pkg::CC_START];
  assign conv_done   = (state_reg == S_DEINT) && (count_reg == STEP_LAST)
                       && (integrator_zero_in || (ref_steps_reg == 8'hff));
  assign irq_clear   = hit(link.rd, link.addr, pmic_pkg::ADDR_INT_REQ);
  assign low_mode    = standby_mode_in || power_off_mode_in || charger_standby_in
                       || force_standby_reg;

  // edge events; standby does not gate capture, and no source outranks another
  always_comb begin
    events = pmic_pkg::ZERO_BYTE;
    events[pmic_pkg::EV_ADAPTER_CONNECT] = adapter_supply_in && !adapter_prev_reg;
    events[pmic_pkg::EV_ADAPTER_REMOVE]  = !adapter_supply_in && adapter_prev_reg;
    events[pmic_pkg::EV_USB_CONNECT]     = usb_present_in && !usb_prev_reg;
    events[pmic_pkg::EV_USB_DISCONNECT]  = !usb_present_in && usb_prev_reg;
    events[pmic_pkg::EV_BATTERY_LOW]     = battery_low_warn_in && !batt_prev_reg;
    events[pmic_pkg::EV_THERMAL_ALARM]   = thermal_alarm_in && !thermal_prev_reg;
    events[pmic_pkg::EV_CONV_DONE]       = conv_done;
    events[pmic_pkg::EV_CHG_TIMEOUT]     = safety_timer_expired_in && !timer_prev_reg;
  end

  // events in the clearing cycle go to the hidden buffer instead of being lost
  always_comb begin
    if (irq_clear) begin
      interrupt_request_next = pmic_pkg::ZERO_BYTE;
      pending_hold_next      = pending_hold_reg | events;
    end else begin
      interrupt_request_next = interrupt_request_reg | pending_hold_reg | events;
      pending_hold_next      = pmic_pkg::ZERO_BYTE;
    end
  end

  // all control state takes its reset value while the power-on reset is low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      adapter_prev_reg <= 1'b0;
      usb_prev_reg     <= 1'b0;
      batt_prev_reg    <= 1'b0;
      thermal_prev_reg <= 1'b0;
      timer_prev_reg   <= 1'b0;
    end else if (ce) begin
      adapter_prev_reg <= adapter_supply_in;
      usb_prev_reg     <= usb_present_in;
      batt_prev_reg    <= battery_low_warn_in;
      thermal_prev_reg <= thermal_alarm_in;
      timer_prev_reg   <= safety_timer_expired_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      interrupt_request_reg <= pmic_pkg::ZERO_BYTE;
      pending_hold_reg      <= pmic_pkg::ZERO_BYTE;
      irq_drive_reg         <= 1'b0;
    end else if (ce) begin
      interrupt_request_reg <= interrupt_request_next;
      pending_hold_reg      <= pending_hold_next;
      // pin drops one cycle after a clearing read, then returns if any unmasked event pended
      irq_drive_reg <= |(interrupt_request_next & ~interrupt_mask_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      interrupt_mask_reg <= pmic_pkg::INT_MASK_RESET;
    end else if (ce && hit(link.wr, link.addr, pmic_pkg::ADDR_INT_MASK)) begin
      interrupt_mask_reg <= link.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      converter_control_reg <= pmic_pkg::CONV_CTRL_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        converter_control_reg <= (link.wdata & pmic_pkg::CC_WRITE_MASK)
                                 | (converter_control_reg & ~pmic_pkg::CC_WRITE_MASK);
        if (start_write) begin
          converter_control_reg[pmic_pkg::CC_DONE] <= 1'b0;
        end
      end
      if (conv_done) begin
        converter_control_reg[pmic_pkg::CC_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      start_pending_reg <= 1'b0;
    end else if (ce) begin
      if (start_write && (link.wdata[pmic_pkg::CC_ENABLE] || enabled)) begin
        start_pending_reg <= 1'b1;
      end else if (!enabled || (state_reg == S_INTEG)) begin
        start_pending_reg <= 1'b0;
      end
    end
  end

  // only off-to-on needs warm-up; warm state survives while enable stays set
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg     <= S_IDLE;
      count_reg     <= COUNT_ZERO;
      ref_steps_reg <= pmic_pkg::ZERO_BYTE;
      warm_done_reg <= 1'b0;
    end else if (ce) begin
      if (!enabled) begin
        state_reg     <= S_IDLE;
        count_reg     <= COUNT_ZERO;
        warm_done_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            count_reg <= COUNT_ZERO;
            if (!warm_done_reg) begin
              state_reg <= S_WARM;
            end else if (start_pending_reg) begin
              state_reg <= S_INTEG;
            end
          end
          S_WARM: begin
            count_reg <= count_reg + 17'h0_0001;
            if (count_reg == WARM_LAST) begin
              warm_done_reg <= 1'b1;
              state_reg     <= S_IDLE;
            end
          end
          S_INTEG: begin
            count_reg <= count_reg + 17'h0_0001;
            if (count_reg == INTEG_LAST) begin
              count_reg     <= COUNT_ZERO;
              ref_steps_reg <= pmic_pkg::ZERO_BYTE;
              state_reg     <= S_DEINT;
            end
          end
          S_DEINT: begin
            count_reg <= count_reg + 17'h0_0001;
            if (count_reg == STEP_LAST) begin
              count_reg     <= COUNT_ZERO;
              ref_steps_reg <= ref_steps_reg + 8'h01;
              if (conv_done) begin
                state_reg <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      converter_result_reg <= pmic_pkg::ZERO_BYTE;
    end else if (ce && conv_done) begin
      converter_result_reg <= ref_steps_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_reg <= pmic_pkg::ZERO_BYTE;
    end else if (ce) begin
      if (hit(link.rd, link.addr, pmic_pkg::ADDR_CONV_CTRL)) begin
        rdata_reg <= converter_control_reg;
      end else if (hit(link.rd, link.addr, pmic_pkg::ADDR_CONV_RESULT)) begin
        rdata_reg <= converter_result_reg;
      end else if (hit(link.rd, link.addr, pmic_pkg::ADDR_INT_MASK)) begin
        rdata_reg <= interrupt_mask_reg;
      end else if (irq_clear) begin
        rdata_reg <= interrupt_request_reg | pending_hold_reg;
      end else begin
        rdata_reg <= pmic_pkg::ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      force_standby_reg <= 1'b0;
    end else if (ce) begin
      force_standby_reg <= thermal_shutdown_in;
    end
  end

  // release delay restarts from zero every time a low-power mode is seen
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rst_count_reg <= COUNT_ZERO;
      rst_drive_reg <= 1'b1;
    end else if (ce) begin
      if (low_mode) begin
        rst_count_reg <= COUNT_ZERO;
        rst_drive_reg <= 1'b1;
      end else if (rst_count_reg == REL_LAST) begin
        rst_drive_reg <= 1'b0;
      end else begin
        rst_count_reg <= rst_count_reg + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      source_select       <= pmic_pkg::SRC_BATT_VOLT;
      range_wide          <= 1'b0;
      converter_powered   <= 1'b0;
      integrate_input     <= 1'b0;
      integrate_reference <= 1'b0;
    end else if (ce) begin
      source_select       <= converter_control_reg[pmic_pkg::CC_SRC_LSB +: 2];
      range_wide          <= converter_control_reg[pmic_pkg::CC_RANGE];
      converter_powered   <= enabled;
      integrate_input     <= (state_reg == S_INTEG);
      integrate_reference <= (state_reg == S_DEINT) && !conv_done;
    end
  end

  assign force_standby = force_standby_reg;
  assign link.rdata    = rdata_reg;
  assign link.irq_o    = 1'b0;
  assign link.irq_oe   = irq_drive_reg;
  assign link.rst_o    = 1'b0;
  assign link.rst_oe   = rst_drive_reg;
endmodule : pmic_device

// File: common/pmic_pkg.sv
package pmic_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // device register map
  localparam logic [7:0] ADDR_CONV_CTRL   = 8'h0a;
  localparam logic [7:0] ADDR_CONV_RESULT = 8'h0b;
  localparam logic [7:0] ADDR_INT_MASK    = 8'h0c;
  localparam logic [7:0] ADDR_INT_REQ     = 8'h0d;
  // converter control fields
  localparam int CC_SRC_LSB = 0;
  localparam int CC_ENABLE  = 2;
  localparam int CC_START   = 3;
  localparam int CC_DONE    = 4;
  localparam int CC_RANGE   = 7;
  localparam logic [7:0] CC_WRITE_MASK = 8'h8f;
  // converter sources
  localparam logic [1:0] SRC_BATT_VOLT = 2'h0;
  localparam logic [1:0] SRC_CHG_CURR  = 2'h1;
  localparam logic [1:0] SRC_EXT_A     = 2'h2;
  localparam logic [1:0] SRC_EXT_B     = 2'h3;
  // interrupt bit positions
  localparam int EV_ADAPTER_CONNECT = 0;
  localparam int EV_ADAPTER_REMOVE  = 1;
  localparam int EV_USB_CONNECT     = 2;
  localparam int EV_USB_DISCONNECT  = 3;
  localparam int EV_BATTERY_LOW     = 4;
  localparam int EV_THERMAL_ALARM   = 5;
  localparam int EV_CONV_DONE       = 6;
  localparam int EV_CHG_TIMEOUT     = 7;
  // reset values
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_MASK_RESET  = 8'h00;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int WARMUP_US       = 2000;
  localparam int INTEG_US        = 2000;
  localparam int REF_STEPS       = 256;
  localparam int WARMUP_CYCLES   = (WARMUP_US * (CLK_HZ / 1_000_000));
  localparam int INTEG_CYCLES    = (INTEG_US * (CLK_HZ / 1_000_000));
  localparam int STEP_CYCLES     = INTEG_CYCLES / REF_STEPS;
  localparam int RELEASE_CYCLES  = 1000;
  localparam int COUNT_W         = 17;
  // host controller register map
  localparam logic [7:0] HOST_ADDR_CMD    = 8'h00;
  localparam logic [7:0] HOST_ADDR_MASK   = 8'h01;
  localparam logic [7:0] HOST_ADDR_STATUS = 8'h02;
  localparam logic [7:0] HOST_ADDR_EVENTS = 8'h03;
  localparam logic [7:0] HOST_ADDR_RESULT = 8'h04;
  localparam int HC_SRC_LSB = 0;
  localparam int HC_RANGE   = 2;
  localparam int HC_ENABLE  = 3;
  localparam int HC_PACK    = 4;
  localparam int HC_GO      = 5;
  localparam logic [7:0] HOST_CMD_RESET = 8'h00;
endpackage : pmic_pkg

// File: common/pmic_if.sv
interface pmic_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq_o;
  logic       irq_oe;
  logic       rst_o;
  logic       rst_oe;
  logic       power_acknowledge_in;
  logic       interrupt_request_out_n;
  logic       system_reset_out_n;

  // open-drain wires with pull-up
  assign interrupt_request_out_n = irq_oe ? irq_o : 1'b1;
  assign system_reset_out_n      = rst_oe ? rst_o : 1'b1;

  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    input  power_acknowledge_in,
    output rdata,
    output irq_o,
    output irq_oe,
    output rst_o,
    output rst_oe
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    output power_acknowledge_in,
    input  rdata,
    input  interrupt_request_out_n,
    input  system_reset_out_n
  );
endinterface : pmic_if

// File: rtl/pmic_host.sv
module pmic_host (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  pmic_if.host            link,
  input  wire logic [7:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata
);
  // read data stands only the cycle after the strobe, so each read waits one cycle
  typedef enum logic [5:0] {
    H_IDLE     = 6'b00_0001,
    H_START    = 6'b00_0010,
    H_IRQ_WAIT = 6'b00_0100,
    H_IRQ_CAP  = 6'b00_1000,
    H_RES_WAIT = 6'b01_0000,
    H_RES_CAP  = 6'b10_0000
  } host_state_e;

  host_state_e state_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  events_reg;
  logic [7:0]  events_next;
  logic [7:0]  result_reg;
  logic [7:0]  sw_rdata_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic        cfg_pending_reg;
  logic        mask_pending_reg;
  logic [7:0]  captured;
  logic        cfg_write;
  logic        mask_write;
  logic        take_cfg;
  logic        take_mask;

  function automatic logic [7:0] ctrl_value(input logic [7:0] c, input logic start);
    ctrl_value = pmic_pkg::ZERO_BYTE;
    ctrl_value[pmic_pkg::CC_SRC_LSB +: 2] = c[pmic_pkg::HC_SRC_LSB +: 2];
    ctrl_value[pmic_pkg::CC_RANGE]        = c[pmic_pkg::HC_RANGE];
    ctrl_value[pmic_pkg::CC_ENABLE]       = c[pmic_pkg::HC_ENABLE];
    ctrl_value[pmic_pkg::CC_START]        = start;
  endfunction : ctrl_value

  assign cfg_write  = sw_wr && (sw_addr == pmic_pkg::HOST_ADDR_CMD);
  assign mask_write = sw_wr && (sw_addr == pmic_pkg::HOST_ADDR_MASK);
  // a request line low outranks queued writes so events are fetched promptly
  assign take_mask  = (state_reg == H_IDLE) && link.interrupt_request_out_n
                      && mask_pending_reg;
  assign take_cfg   = (state_reg == H_IDLE) && link.interrupt_request_out_n
                      && !mask_pending_reg && cfg_pending_reg;
  assign captured   = (state_reg == H_IRQ_CAP) ? link.rdata : pmic_pkg::ZERO_BYTE;
  // software sees every source; servicing order is its own decision
  assign events_next = (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_EVENTS))
                       ? captured : (events_reg | captured);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_reg          <= pmic_pkg::HOST_CMD_RESET;
      mask_reg         <= pmic_pkg::INT_MASK_RESET;
      cfg_pending_reg  <= 1'b0;
      mask_pending_reg <= 1'b0;
    end else if (ce) begin
      if (cfg_write) begin
        cmd_reg <= sw_wdata;
      end
      if (mask_write) begin
        mask_reg <= sw_wdata;
      end
      cfg_pending_reg  <= cfg_write || (cfg_pending_reg && !take_cfg);
      mask_pending_reg <= mask_write || (mask_pending_reg && !take_mask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg  <= H_IDLE;
      addr_reg   <= pmic_pkg::ZERO_BYTE;
      wdata_reg  <= pmic_pkg::ZERO_BYTE;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      result_reg <= pmic_pkg::ZERO_BYTE;
    end else if (ce) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (!link.interrupt_request_out_n) begin
            rd_reg    <= 1'b1;
            addr_reg  <= pmic_pkg::ADDR_INT_REQ;
            state_reg <= H_IRQ_WAIT;
          end else if (take_mask) begin
            wr_reg    <= 1'b1;
            addr_reg  <= pmic_pkg::ADDR_INT_MASK;
            wdata_reg <= mask_reg;
          end else if (take_cfg) begin
            // source and range land with start low, so they settle before the start
            wr_reg    <= 1'b1;
            addr_reg  <= pmic_pkg::ADDR_CONV_CTRL;
            wdata_reg <= ctrl_value(cmd_reg, 1'b0);
            if (cmd_reg[pmic_pkg::HC_GO]) begin
              state_reg <= H_START;
            end
          end
        end
        H_START: begin
          wr_reg    <= 1'b1;
          addr_reg  <= pmic_pkg::ADDR_CONV_CTRL;
          wdata_reg <= ctrl_value(cmd_reg, 1'b1);
          state_reg <= H_IDLE;
        end
        H_IRQ_WAIT: begin
          state_reg <= H_IRQ_CAP;
        end
        H_IRQ_CAP: begin
          if (link.rdata[pmic_pkg::EV_CONV_DONE]) begin
            rd_reg    <= 1'b1;
            addr_reg  <= pmic_pkg::ADDR_CONV_RESULT;
            state_reg <= H_RES_WAIT;
          end else begin
            state_reg <= H_IDLE;
          end
        end
        H_RES_WAIT: begin
          state_reg <= H_RES_CAP;
        end
        H_RES_CAP: begin
          result_reg <= link.rdata;
          state_reg  <= H_IDLE;
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      events_reg <= pmic_pkg::ZERO_BYTE;
    end else if (ce) begin
      events_reg <= events_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sw_rdata_reg <= pmic_pkg::ZERO_BYTE;
    end else if (ce) begin
      if (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_CMD)) begin
        sw_rdata_reg <= cmd_reg;
      end else if (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_MASK)) begin
        sw_rdata_reg <= mask_reg;
      end else if (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_STATUS)) begin
        sw_rdata_reg <= {5'h00, !link.system_reset_out_n, !link.interrupt_request_out_n,
                         (state_reg != H_IDLE) || cfg_pending_reg || mask_pending_reg};
      end else if (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_EVENTS)) begin
        sw_rdata_reg <= events_reg;
      end else if (sw_rd && (sw_addr == pmic_pkg::HOST_ADDR_RESULT)) begin
        sw_rdata_reg <= result_reg;
      end else begin
        sw_rdata_reg <= pmic_pkg::ZERO_BYTE;
      end
    end
  end

  assign sw_rdata                  = sw_rdata_reg;
  assign link.addr                 = addr_reg;
  assign link.wdata                = wdata_reg;
  assign link.wr                   = wr_reg;
  assign link.rd                   = rd_reg;
  // the acknowledge pin follows a software bit for serial-less power cycling
  assign link.power_acknowledge_in = cmd_reg[pmic_pkg::HC_PACK];
endmodule : pmic_host

// File: tb/pmic_sva.sv
module pmic_sva (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq_oe,
  input wire logic       rst_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  AST_NO_WR_RD:
    assert property (!(wr && rd)) else $error("both strobes high");
  AST_START_PAIR:
    assert property (wr && addr == pmic_pkg::ADDR_CONV_CTRL && wdata[3]
      |-> $past(wr && addr == pmic_pkg::ADDR_CONV_CTRL && !wdata[3])) else $error("bad start");
  AST_RDATA_IDLE:
    assert property (!$past(rd) |-> rdata == pmic_pkg::ZERO_BYTE) else $error("stray rdata");
  AST_READ_NONZERO:
    assert property ($past(rd && addr == pmic_pkg::ADDR_INT_REQ && irq_oe) |-> rdata != 8'h00)
      else $error("request with empty register");
  // the mask path is one stage longer, so both depths are allowed
  AST_IRQ_FALL:
    assert property ($fell(irq_oe) |-> $past(rd && addr == pmic_pkg::ADDR_INT_REQ)
      || $past(wr && addr == pmic_pkg::ADDR_INT_MASK)
      || $past(wr && addr == pmic_pkg::ADDR_INT_MASK, 2)) else $error("request dropped");
  // eight matches the release count the bench sets
  AST_SYSRST_HOLD:
    assert property ($rose(rstn) |-> rst_oe [*8] ##[1:4] !rst_oe) else $error("reset release");
  AST_RESET_QUIET:
    assert property ($rose(rstn) |-> !irq_oe) else $error("request after reset");
  AST_RESULT_FETCH:
    assert property ($past(rd && addr == pmic_pkg::ADDR_INT_REQ) && rdata[6]
      |-> ##[0:3] (rd && addr == pmic_pkg::ADDR_CONV_RESULT)) else $error("no result fetch");
endmodule : pmic_sva

// File: tb/pmic_adc_sequencer_and_interrupt_tb.sv
module pmic_adc_sequencer_and_interrupt_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic [7:0] sw_rdata;
  logic       sw_wr = 1'b0;
  logic       sw_rd = 1'b0;
  logic [7:0] ev = 8'h00;
  logic       integ_zero = 1'b1;
  logic       chg_stby = 1'b0;
  logic [1:0] src;
  logic       rng;
  logic       pwr;
  logic       fstb;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  pmic_if link ();
  pmic_device #(.WARMUP_CYCLES(20), .INTEG_CYCLES(20), .STEP_CYCLES(2), .RELEASE_CYCLES(8))
    u_pmic_device (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .link(link.device),
    .adapter_supply_in(ev[0]), .usb_present_in(ev[1]), .battery_low_warn_in(ev[2]),
    .thermal_alarm_in(ev[3]), .safety_timer_expired_in(ev[4]), .thermal_shutdown_in(ev[5]),
    .standby_mode_in(ev[6]), .power_off_mode_in(ev[7]), .charger_standby_in(chg_stby),
    .integrator_zero_in(integ_zero), .source_select(src), .range_wide(rng),
    .converter_powered(pwr), .integrate_input(), .integrate_reference(), .force_standby(fstb));
  pmic_host u_pmic_host (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .link(link.host),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  pmic_sva u_pmic_sva (.sys_clk(sys_clk), .rstn(rstn), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq_oe(link.irq_oe), .rst_oe(link.rst_oe));
  always #10 sys_clk = ~sys_clk;
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 cmp("sw_rdata", e, sw_rdata);
  endtask : rd
  // ten cycles leave the host time to service any request
  task automatic set_ev(input logic [7:0] v);
    @(posedge sys_clk);
    ev <= v;
    repeat (10) @(posedge sys_clk);
  endtask : set_ev
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rd(pmic_pkg::HOST_ADDR_STATUS, 8'h00);
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h00);
    $display("reset test done");
    set_ev(8'h1f);
    set_ev(8'h00);
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'hbf);
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h00);
    $display("event test done");
    wr(pmic_pkg::HOST_ADDR_MASK, 8'h04);
    // the mask reaches the device a few cycles after the software write
    repeat (4) @(posedge sys_clk);
    set_ev(8'h02);
    rd(pmic_pkg::HOST_ADDR_STATUS, 8'h00);
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h00);
    wr(pmic_pkg::HOST_ADDR_MASK, 8'h00);
    set_ev(8'h00);
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h0c);
    $display("mask test done");
    // second pass toggles start again and never crosses zero, so it runs to full scale
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      integ_zero <= (i == 0);
      wr(pmic_pkg::HOST_ADDR_CMD, 8'h2e);
      repeat ((i == 0) ? 100 : 600) @(posedge sys_clk);
      cmp("converter outputs", 8'h0e, {4'h0, pwr, rng, src});
      rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h40);
      rd(pmic_pkg::HOST_ADDR_RESULT, (i == 0) ? 8'h00 : 8'hff);
    end
    $display("conversion test done");
    @(posedge sys_clk);
    chg_stby <= 1'b1;
    set_ev(8'h00);
    rd(pmic_pkg::HOST_ADDR_STATUS, 8'h04);
    @(posedge sys_clk);
    chg_stby <= 1'b0;
    set_ev(8'hc0);
    rd(pmic_pkg::HOST_ADDR_STATUS, 8'h04);
    set_ev(8'hc1);
    set_ev(8'h20);
    cmp("force_standby", 8'h01, {7'h00, fstb});
    rd(pmic_pkg::HOST_ADDR_EVENTS, 8'h03);
    set_ev(8'h00);
    rd(pmic_pkg::HOST_ADDR_STATUS, 8'h00);
    wr(pmic_pkg::HOST_ADDR_CMD, 8'h10);
    #1 cmp("power_ack", 8'h01, {7'h00, link.power_acknowledge_in});
    $display("low mode test done");
    print_verdict();
  end
endmodule : pmic_adc_sequencer_and_interrupt_tb
